// file: gate_teach_ctrl.sv
// Teach-in sequencer and two-channel safety output logic of the coded gate switch
module gate_teach_ctrl #(
  parameter int unsigned MS_CYCLES     = teach_pkg::MS_CYCLES_DEF,
  parameter int unsigned SLOW_PHASE_MS = teach_pkg::TEACH_SLOW_MS,
  parameter int unsigned CONFIRM_WIN_MS = teach_pkg::CONFIRM_MS
) (
  input  wire logic                                         clk,
  input  wire logic                                         reset,
  input  wire logic                                         actuator_present,
  input  wire logic                                         actuator_single,
  input  wire logic [teach_pkg::ID_W-1:0]                   actuator_id,
  input  wire logic                                         safety_in_ch1,
  input  wire logic                                         safety_in_ch2,
  input  wire logic                                         nv_learned_in,
  input  wire logic [teach_pkg::ID_W-1:0]                   nv_id_in,
  input  wire logic [teach_pkg::LEFT_W-1:0]                 nv_left_in,
  input  wire logic                                         nv_pend_in,
  input  wire logic [teach_pkg::ID_W-1:0]                   nv_pend_id_in,
  input  wire logic [teach_pkg::TEACH_MAX-1:0][teach_pkg::ID_W-1:0] nv_retired_in,
  output logic                                              nv_learned_out,
  output logic [teach_pkg::ID_W-1:0]                        nv_id_out,
  output logic [teach_pkg::LEFT_W-1:0]                      nv_left_out,
  output logic                                              nv_pend_out,
  output logic [teach_pkg::ID_W-1:0]                        nv_pend_id_out,
  output logic [teach_pkg::TEACH_MAX-1:0][teach_pkg::ID_W-1:0] nv_retired_out,
  output logic                                              nv_write,
  output logic                                              safety_out_ch1,
  output logic                                              safety_out_ch2,
  output logic                                              signal_diag_output,
  output logic                                              gate_led,
  output logic                                              input_led,
  output logic                                              device_led_green,
  output logic                                              device_led_red,
  output logic                                              plaus_fault
);
  import teach_pkg::*;

  teach_state_t                       state_reg, state_next;
  logic [31:0]                        ms_reg, ms_next;
  logic                               learned_reg, learned_next;
  logic [ID_W-1:0]                    id_reg, id_next;
  logic [LEFT_W-1:0]                  left_reg, left_next;
  logic                               pend_reg, pend_next;
  logic [ID_W-1:0]                    pend_id_reg, pend_id_next;
  logic [TEACH_MAX-1:0][ID_W-1:0]     retired_reg, retired_next;
  logic                               write_reg, write_next;
  logic                               ch1_prev_reg, ch2_prev_reg;
  logic                               fault_reg;
  logic                               out_reg, diag_reg;
  logic                               gate_led_reg, input_led_reg, green_reg, red_reg;
  logic                               ms_tick, slow_on, quick_on;

  ms_flash_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
    .clk      (clk),
    .reset    (reset),
    .ms_tick  (ms_tick),
    .slow_on  (slow_on),
    .quick_on (quick_on)
  );

  // Retired slots in use: one per adoption already consumed from the count
  wire [LEFT_W-1:0] used_slots = LEFT_MAX - left_reg;
  wire [LEFT_W-1:0] load_idx   = LEFT_MAX - nv_left_in;
  logic [TEACH_MAX-1:0] retired_hit;
  genvar gi;
  generate
    for (gi = 0; gi < TEACH_MAX; gi++) begin : g_retired
      assign retired_hit[gi] = (LEFT_W'(gi) < used_slots) && (retired_reg[gi] == actuator_id);
    end
  endgenerate

  // Actuator classification
  wire in_range    = actuator_present && actuator_single;
  wire known       = learned_reg && actuator_present && (actuator_id == id_reg);
  wire first_seen  = in_range && !learned_reg;
  wire used_before = |retired_hit;
  wire count_left  = (left_reg != '0);
  wire newcomer    = in_range && learned_reg && !known && !used_before && count_left;
  wire pend_stays  = actuator_present && (actuator_id == pend_id_reg);
  wire slow_done   = ms_tick && (ms_reg == SLOW_PHASE_MS - 1);
  wire window_over = ms_tick && (ms_reg == CONFIRM_WIN_MS - 1);
  wire adopt       = nv_learned_in && nv_pend_in && (nv_left_in != '0);

  // Sequencer next state; every change of the learned image is flagged for the store
  always_comb begin
    state_next   = state_reg;
    ms_next      = ms_reg;
    learned_next = learned_reg;
    id_next      = id_reg;
    left_next    = left_reg;
    pend_next    = pend_reg;
    pend_id_next = pend_id_reg;
    retired_next = retired_reg;
    write_next   = 1'b0;
    case (state_reg)
      ST_LOAD: begin
        state_next   = ST_RUN;
        learned_next = nv_learned_in;
        id_next      = nv_id_in;
        left_next    = nv_left_in;
        pend_next    = 1'b0;
        pend_id_next = nv_pend_id_in;
        retired_next = nv_retired_in;
        write_next   = nv_pend_in;
        if (adopt) begin
          retired_next[load_idx[IDX_W-1:0]] = nv_id_in;
          id_next   = nv_pend_id_in;
          left_next = nv_left_in - LEFT_ONE;
        end
      end
      ST_RUN: begin
        if (first_seen) begin
          learned_next = 1'b1;
          id_next      = actuator_id;
          write_next   = 1'b1;
        end else if (newcomer) begin
          state_next   = ST_TEACH_SLOW;
          ms_next      = '0;
          pend_id_next = actuator_id;
        end
      end
      ST_TEACH_SLOW: begin
        if (!pend_stays) begin
          state_next = ST_RUN;
        end else if (slow_done) begin
          state_next = ST_TEACH_QUICK;
          ms_next    = '0;
          pend_next  = 1'b1;
          write_next = 1'b1;
        end else if (ms_tick) begin
          ms_next = ms_reg + MS_ONE;
        end
      end
      ST_TEACH_QUICK: begin
        if (!pend_stays || window_over) begin
          state_next = ST_RUN;
          pend_next  = 1'b0;
          write_next = 1'b1;
        end else if (ms_tick) begin
          ms_next = ms_reg + MS_ONE;
        end
      end
      default: begin
        state_next = ST_LOAD;
      end
    endcase
  end

  // Sequencer registers; the learned image is fetched from the store after each power-up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg   <= ST_LOAD;
      ms_reg      <= '0;
      learned_reg <= 1'b0;
      id_reg      <= '0;
      left_reg    <= '0;
      pend_reg    <= 1'b0;
      pend_id_reg <= '0;
      retired_reg <= '0;
      write_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ms_reg      <= ms_next;
      learned_reg <= learned_next;
      id_reg      <= id_next;
      left_reg    <= left_next;
      pend_reg    <= pend_next;
      pend_id_reg <= pend_id_next;
      retired_reg <= retired_next;
      write_reg   <= write_next;
    end
  end

  // Plausibility: a lone input coming back high without a common low is a fault
  wire both_high  = safety_in_ch1 && safety_in_ch2;
  wire both_low   = !safety_in_ch1 && !safety_in_ch2;
  wire lone_rise  = both_high && (ch1_prev_reg != ch2_prev_reg);
  wire fault_next = both_low ? 1'b0 : (lone_rise | fault_reg);
  wire gate_ok    = known && (state_reg == ST_RUN);
  wire out_next   = gate_ok && both_high && !fault_next;

  // Output path is one register deep, keeping the per-switch delay bounded
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ch1_prev_reg <= 1'b0;
      ch2_prev_reg <= 1'b0;
      fault_reg    <= 1'b0;
      out_reg      <= 1'b0;
      diag_reg     <= 1'b0;
    end else begin
      ch1_prev_reg <= safety_in_ch1;
      ch2_prev_reg <= safety_in_ch2;
      fault_reg    <= fault_next;
      out_reg      <= out_next;
      diag_reg     <= gate_ok;
    end
  end

  // Indicators follow the teach phase and the plausibility state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_led_reg  <= 1'b0;
      input_led_reg <= 1'b0;
      green_reg     <= 1'b0;
      red_reg       <= 1'b0;
    end else begin
      gate_led_reg  <= (state_reg == ST_TEACH_SLOW) ? slow_on :
                       (state_reg == ST_TEACH_QUICK) ? quick_on :
                       actuator_present;
      input_led_reg <= fault_reg ? slow_on : both_high;
      green_reg     <= !fault_reg;
      red_reg       <= fault_reg && slow_on;
    end
  end

  // Both channels share one register so they cannot disagree on their own
  assign safety_out_ch1     = out_reg;
  assign safety_out_ch2     = out_reg;
  assign signal_diag_output = diag_reg;
  assign gate_led           = gate_led_reg;
  assign input_led          = input_led_reg;
  assign device_led_green   = green_reg;
  assign device_led_red     = red_reg;
  assign plaus_fault        = fault_reg;
  assign nv_learned_out     = learned_reg;
  assign nv_id_out          = id_reg;
  assign nv_left_out        = left_reg;
  assign nv_pend_out        = pend_reg;
  assign nv_pend_id_out     = pend_id_reg;
  assign nv_retired_out     = retired_reg;
  assign nv_write           = write_reg;
endmodule // gate_teach_ctrl

// file: teach_pkg.sv
// Constants shared by the coded gate switch teach and safety output logic
// Behaviour
// - First detected actuator learned automatically when none learned
// - At most eight learning procedures, remaining count kept
// - New actuator starts learning, gate indicator slow flash
// - After twenty seconds gate indicator flashes quickly
// - Next power-up adopts new actuator, count minus one; code adopts only on power-up within the quick-flash confirm window
// - Previously learned, replaced actuators are never relearned
// - Safety inputs accept upstream outputs, up to 32
// - With diagnostics bus, at most 16 capable switches
// - Opening any gate drives both chain outputs low
// - Chain turn-off latency bounded by per-switch delays
// - Lone input low-to-high return flags plausibility lockout
// - Outputs resume only after both inputs seen low
package teach_pkg;
  localparam int unsigned ID_W            = 16;
  localparam int unsigned LEFT_W          = 4;
  localparam int unsigned IDX_W           = 3;
  localparam int unsigned TEACH_MAX       = 8;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned MS_CYCLES_DEF   = CLK_HZ / MS_PER_S;
  localparam int unsigned TEACH_SLOW_S    = 20;
  localparam int unsigned CONFIRM_S       = 120;
  localparam int unsigned TEACH_SLOW_MS   = TEACH_SLOW_S * MS_PER_S;
  localparam int unsigned CONFIRM_MS      = CONFIRM_S * MS_PER_S;
  localparam int unsigned PHASE_W         = 10;
  localparam logic [PHASE_W-1:0] FLASH_PERIOD_MS = 10'h3E8;
  localparam logic [PHASE_W-1:0] SLOW_ON_MS      = 10'h1F4;
  localparam logic [PHASE_W-1:0] QUICK_ON_MS     = 10'h032;
  localparam logic [LEFT_W-1:0]  LEFT_MAX        = 4'h8;
  localparam logic [LEFT_W-1:0]  LEFT_ONE        = 4'h1;
  localparam logic [31:0]        MS_ONE          = 32'h0000_0001;
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_TEACH_SLOW, ST_TEACH_QUICK} teach_state_t;
endpackage

// file: ms_flash_timer.sv
// Millisecond tick divider and indicator flash pattern phases
module ms_flash_timer #(
  parameter int unsigned MS_CYCLES = teach_pkg::MS_CYCLES_DEF
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      ms_tick,
  output logic      slow_on,
  output logic      quick_on
);
  import teach_pkg::*;

  logic [31:0]        div_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic               tick_reg;
  logic               slow_reg;
  logic               quick_reg;
  wire                div_wrap   = (div_reg == MS_CYCLES - 1);
  wire                phase_wrap = (phase_reg == FLASH_PERIOD_MS - 10'h001);

  // Divider and one-second flash phase; patterns are registered so they never glitch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg   <= '0;
      phase_reg <= '0;
      tick_reg  <= 1'b0;
      slow_reg  <= 1'b0;
      quick_reg <= 1'b0;
    end else begin
      div_reg  <= div_wrap ? '0 : div_reg + MS_ONE;
      tick_reg <= div_wrap;
      if (div_wrap) begin
        phase_reg <= phase_wrap ? '0 : phase_reg + 10'h001;
      end
      slow_reg  <= (phase_reg < SLOW_ON_MS);
      quick_reg <= (phase_reg < QUICK_ON_MS);
    end
  end

  assign ms_tick  = tick_reg;
  assign slow_on  = slow_reg;
  assign quick_on = quick_reg;
endmodule // ms_flash_timer

// file: gate_teach_assertions.sv
// Checker for the gate switch teach and safety output logic
module gate_teach_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic actuator_present,
  input wire logic safety_in_ch1,
  input wire logic safety_in_ch2,
  input wire logic nv_write,
  input wire logic safety_out_ch1,
  input wire logic safety_out_ch2,
  input wire logic device_led_green,
  input wire logic plaus_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // One channel comes back high while the other never went low
  sequence lone_return;
    (safety_in_ch1 ^ safety_in_ch2) ##1 (safety_in_ch1 && safety_in_ch2);
  endsequence
  // Fault standing a while with an input still high
  sequence fault_with_high;
    (plaus_fault && (safety_in_ch1 || safety_in_ch2)) [*2];
  endsequence
  a_chan_equal: assert property (safety_out_ch1 == safety_out_ch2)
    else $error("safety channels differ");
  a_in_low: assert property (!safety_in_ch1 |-> ##[1:2] !safety_out_ch1)
    else $error("output high after input low");
  a_gone_low: assert property (!actuator_present [*3] |-> !safety_out_ch1)
    else $error("output high with gate open");
  a_fault_set: assert property (lone_return |-> ##[1:3] plaus_fault)
    else $error("lone return not flagged");
  a_fault_hold: assert property (fault_with_high |=> plaus_fault)
    else $error("fault cleared without both low");
  a_fault_out: assert property (plaus_fault [*2] |-> !safety_out_ch1)
    else $error("output high during fault");
  a_green_fault: assert property (plaus_fault [*2] |-> !device_led_green)
    else $error("green lit during fault");
  a_write_pulse: assert property (nv_write |=> !nv_write)
    else $error("store write longer than one cycle");
endmodule // gate_teach_assertions

bind gate_teach_ctrl gate_teach_assertions i_gate_teach_assertions (.clk, .reset, .actuator_present,
  .safety_in_ch1, .safety_in_ch2, .nv_write, .safety_out_ch1, .safety_out_ch2, .device_led_green, .plaus_fault);

// file: chain_partner.sv
// Upstream chained switch and two-channel evaluator around the gate switch
module chain_partner (
  input  wire logic clk,
  input  wire logic gate_open,
  input  wire logic lone_drop,
  input  wire logic out_ch1,
  input  wire logic out_ch2,
  output logic      ch1,
  output logic      ch2,
  output logic      disagree
);
  timeunit 1ns;
  timeprecision 1ns;
  // Upstream stage is registered, like a real switch output
  always @(posedge clk) begin
    ch1 <= !gate_open && !lone_drop;
    ch2 <= !gate_open;
  end
  // Evaluator reads both channels on their own
  assign disagree = (out_ch1 !== out_ch2);
endmodule // chain_partner

// file: tb.sv
// Self-checking bench for the gate switch teach logic
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import teach_pkg::*;
  logic clk = 1'h0, reset = 1'h1, pres = 1'h0, single = 1'h1, gate_open = 1'h0, lone = 1'h0;
  logic st_l = 1'h0, st_p = 1'h0;
  logic [ID_W-1:0] id = 16'h0000, st_id = 16'h0000, st_pid = 16'h0000, id_o, pid_o;
  logic [LEFT_W-1:0] st_left = LEFT_MAX, left_o;
  logic [TEACH_MAX-1:0][ID_W-1:0] st_ret = '0, ret_o;
  logic l_o, p_o, wr, o1, o2, diag, green, fault, ch1, ch2, disagree, s, gled, iled, red;
  int err_total = 0, check_count = 0;
  always #10 clk = ~clk;
  // Device under test: short counts keep the teach phases to a few dozen cycles
  gate_teach_ctrl #(.MS_CYCLES(4), .SLOW_PHASE_MS(5), .CONFIRM_WIN_MS(8)) i_gate_teach_ctrl (
    .clk, .reset, .actuator_present(pres), .actuator_single(single), .actuator_id(id),
    .safety_in_ch1(ch1), .safety_in_ch2(ch2), .nv_learned_in(st_l), .nv_id_in(st_id), .nv_left_in(st_left),
    .nv_pend_in(st_p), .nv_pend_id_in(st_pid), .nv_retired_in(st_ret), .nv_learned_out(l_o), .nv_id_out(id_o),
    .nv_left_out(left_o), .nv_pend_out(p_o), .nv_pend_id_out(pid_o), .nv_retired_out(ret_o), .nv_write(wr),
    .safety_out_ch1(o1), .safety_out_ch2(o2), .signal_diag_output(diag), .gate_led(gled), .input_led(iled),
    .device_led_green(green), .device_led_red(red), .plaus_fault(fault));
  chain_partner i_chain_partner (.clk, .gate_open, .lone_drop(lone), .out_ch1(o1), .out_ch2(o2),
    .ch1, .ch2, .disagree);
  // Non-volatile store saves the live image on each write pulse
  always @(posedge clk) begin
    if (wr) begin
      st_l <= l_o;
      st_id <= id_o;
      st_left <= left_o;
      st_p <= p_o;
      st_pid <= pid_o;
      st_ret <= ret_o;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a store write pulse, sampled after the edge settles
  task automatic wait_wr(input int n, output logic seen);
    seen = 1'h0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (wr === 1'h1) begin
        seen = 1'h1;
        break;
      end
    end
  endtask
  // Power cycle modelled as a short reset pulse
  task automatic power();
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
  endtask
  task automatic t_first();
    @(posedge clk);
    id <= 16'hA5A1;
    pres <= 1'h1;
    single <= 1'h1;
    wait_wr(10, s);
    chk(s, 16'h0001);
    chk(id_o, 16'hA5A1);
    chk(left_o, 16'h0008);
    cyc(4);
    chk(o1, 16'h0001);
    chk(diag, 16'h0001);
    chk(gled, 16'h0001);
  endtask
  task automatic t_chain();
    @(posedge clk);
    gate_open <= 1'h1;
    cyc(4);
    chk({o1, o2}, 16'h0000);
    chk(iled, 16'h0000);
    @(posedge clk);
    gate_open <= 1'h0;
    cyc(4);
    chk({o1, o2}, 16'h0003);
    chk(iled, 16'h0001);
    chk(disagree, 16'h0000);
  endtask
  task automatic t_fault();
    @(posedge clk);
    lone <= 1'h1;
    cyc(3);
    chk(o1, 16'h0000);
    @(posedge clk);
    lone <= 1'h0;
    cyc(4);
    chk(fault, 16'h0001);
    chk({o1, green}, 16'h0000);
    chk(red, 16'h0001);
    @(posedge clk);
    gate_open <= 1'h1;
    cyc(4);
    chk(fault, 16'h0000);
    chk(red, 16'h0000);
    @(posedge clk);
    gate_open <= 1'h0;
    cyc(4);
    chk(o1, 16'h0001);
  endtask
  task automatic t_reteach();
    @(posedge clk);
    id <= 16'hB0B2;
    cyc(3);
    chk(o1, 16'h0000);
    wait_wr(40, s);
    chk(s, 16'h0001);
    chk({p_o, 15'h0000}, 16'h8000);
    chk(pid_o, 16'hB0B2);
    power();
    wait_wr(6, s);
    chk(s, 16'h0001);
    chk(id_o, 16'hB0B2);
    chk(left_o, 16'h0007);
    chk(ret_o[0], 16'hA5A1);
    chk(p_o, 16'h0000);
  endtask
  task automatic t_refuse();
    @(posedge clk);
    id <= 16'hA5A1;
    wait_wr(40, s);
    chk(s, 16'h0000);
    chk({p_o, o1}, 16'h0000);
  endtask
  // Newcomer withdrawn in its slow phase: teach dropped, learned actuator still works
  task automatic t_withdraw();
    @(posedge clk);
    id <= 16'hE0E6;
    cyc(8);
    @(posedge clk);
    pres <= 1'h0;
    wait_wr(30, s);
    chk(s, 16'h0000);
    chk({p_o, gled, o1}, 16'h0000);
    @(posedge clk);
    id <= 16'hB0B2;
    pres <= 1'h1;
    cyc(4);
    chk({gled, o1}, 16'h0003);
  endtask
  task automatic t_window();
    @(posedge clk);
    id <= 16'hC3C4;
    wait_wr(40, s);
    chk(s, 16'h0001);
    wait_wr(60, s);
    chk(s, 16'h0001);
    chk(p_o, 16'h0000);
    chk(id_o, 16'hB0B2);
  endtask
  task automatic t_exhaust();
    // Let the store take the abandon write before its count is overwritten
    cyc(1);
    @(posedge clk);
    st_left <= 4'h0;
    id <= 16'hD0D5;
    power();
    wait_wr(60, s);
    chk(s, 16'h0000);
    chk(o1, 16'h0000);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    t_first();
    t_chain();
    t_fault();
    t_reteach();
    t_refuse();
    t_withdraw();
    t_window();
    t_exhaust();
    report_and_stop();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule // tb
